// >>> scp_defs.vh
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH
`define SCP_OP_CLEAR 8'h01
`define SCP_OP_BASE 8'h40
`define SCP_OP_CTRL_WR 3'h0
`define SCP_OP_STAT_RD 3'h1
`define SCP_OP_RXBUF_RD 3'h2
`define SCP_OP_TXBUF_WR 3'h3
`define SCP_OP_SYNC_WR 3'h4
`define SCP_UNIT_BIT 3
`define SCP_CTRL_PSAVE_BIT 2
`define SCP_CTRL_IRQEN_BIT 3
`define SCP_CTRL_RESET 8'h00
`define SCP_FIFO_DEPTH 16
`define SCP_FIFO_AW 4
`define SCP_BYTE_W 8
`define SCP_LAST_BIT 3'h7
`define SCP_SYNC_RESET 16'h0000
`endif

// >>> scp_fifo.v
module scp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst_n,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire do_wr;
   wire do_rd;
   localparam [AW:0] FULL = DEPTH;

   assign in_ready = (count != FULL);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // scp_fifo

// >>> scp_port.v
`include "scp_defs.vh"

module scp_port (
   input wire clk,
   input wire rst_n,
   input wire sel_n,
   input wire sclk,
   input wire cmd_in,
   output reg reply_out,
   output reg reply_oe,
   input wire unit_addr,
   input wire resume,
   input wire [7:0] status_in,
   input wire [7:0] rxbuf_in,
   output wire rxbuf_taken,
   input wire irq_pending,
   output wire irq_out,
   output wire irq_oe,
   input wire tx_active,
   output wire tone_oe,
   output wire tx_valid,
   input wire tx_ready,
   output wire [7:0] tx_data,
   output reg [7:0] ctrl,
   output reg [15:0] sync_word,
   output wire low_power
);
   localparam ST_OPC = 3'h0;
   localparam ST_CTRL = 3'h1;
   localparam ST_TXB = 3'h2;
   localparam ST_SYNC_HI = 3'h3;
   localparam ST_SYNC_LO = 3'h4;
   localparam ST_REPLY = 3'h5;
   localparam ST_IGNORE = 3'h6;

   reg sel_m;
   reg sel_s;
   reg sclk_m;
   reg sclk_s;
   reg sclk_d;
   reg cmd_m;
   reg cmd_s;
   reg unit_m;
   reg unit_s;
   reg res_m;
   reg res_s;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] bit_cnt;
   reg [6:0] shift;
   reg [7:0] reply_sr;
   reg reply_done;
   reg fifo_wr;
   reg [7:0] fifo_wdata;
   reg rx_take;
   wire rise;
   wire fall;
   wire active;
   wire [7:0] byte_in;
   wire byte_done;
   wire fifo_in_ready;
   wire op_mine;
   wire [2:0] op_code;
   wire [7:0] op_base;

   // pins from outside are double-registered first
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_m <= 1'b1;
         sel_s <= 1'b1;
         // idle low, so no false edge after reset
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         cmd_m <= 1'b0;
         cmd_s <= 1'b0;
         unit_m <= 1'b0;
         unit_s <= 1'b0;
         res_m <= 1'b0;
         res_s <= 1'b0;
      end else begin
         sel_m <= sel_n;
         sel_s <= sel_m;
         sclk_m <= sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         cmd_m <= cmd_in;
         cmd_s <= cmd_m;
         unit_m <= unit_addr;
         unit_s <= unit_m;
         res_m <= resume;
         res_s <= res_m;
      end
   end

   assign active = !sel_s;
   assign rise = active && sclk_s && !sclk_d;
   assign fall = active && !sclk_s && sclk_d;
   assign byte_in = {shift, cmd_s};
   assign byte_done = rise && (bit_cnt == `SCP_LAST_BIT);

   assign op_code = byte_in[2:0];
   assign op_base = `SCP_OP_BASE;
   assign op_mine = (byte_in[7:4] == op_base[7:4]) &&
      (byte_in[`SCP_UNIT_BIT] == unit_s) &&
      (op_code <= `SCP_OP_SYNC_WR);

   always @* begin
      next_state = state;
      if (byte_done) begin
         case (state)
            ST_OPC: begin
               if (!op_mine) begin
                  next_state = ST_IGNORE;
               end else begin
                  case (op_code)
                     `SCP_OP_CTRL_WR: next_state = ST_CTRL;
                     `SCP_OP_TXBUF_WR: next_state = ST_TXB;
                     `SCP_OP_SYNC_WR: next_state = ST_SYNC_HI;
                     default: next_state = ST_REPLY;
                  endcase
               end
            end
            ST_SYNC_HI: next_state = ST_SYNC_LO;
            ST_IGNORE: next_state = ST_IGNORE;
            ST_REPLY: next_state = ST_IGNORE;
            default: next_state = ST_IGNORE;
         endcase
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OPC;
         bit_cnt <= 3'h0;
         shift <= 7'h00;
         ctrl <= `SCP_CTRL_RESET;
         sync_word <= `SCP_SYNC_RESET;
         fifo_wr <= 1'b0;
         fifo_wdata <= 8'h00;
         reply_sr <= 8'h00;
         reply_done <= 1'b0;
         rx_take <= 1'b0;
      end else begin
         fifo_wr <= 1'b0;
         rx_take <= 1'b0;
         if (!active) begin
            state <= ST_OPC;
            bit_cnt <= 3'h0;
            reply_done <= 1'b0;
         end else begin
            state <= next_state;
            if (rise) begin
               bit_cnt <= bit_cnt + 3'h1;
               shift <= byte_in[6:0];
            end
            if (byte_done) begin
               case (state)
                  ST_OPC: begin
                     if (byte_in == `SCP_OP_CLEAR) begin
                        ctrl <= `SCP_CTRL_RESET;
                     end
                     if (op_mine && op_code == `SCP_OP_STAT_RD) begin
                        reply_sr <= status_in;
                     end
                     if (op_mine && op_code == `SCP_OP_RXBUF_RD) begin
                        reply_sr <= rxbuf_in;
                        rx_take <= 1'b1;
                     end
                  end
                  ST_CTRL: ctrl <= byte_in;
                  ST_TXB: begin
                     fifo_wr <= 1'b1;
                     fifo_wdata <= byte_in;
                  end
                  ST_SYNC_HI: sync_word[15:8] <= byte_in;
                  ST_SYNC_LO: sync_word[7:0] <= byte_in;
                  ST_REPLY: reply_done <= 1'b1;
                  default: ctrl <= ctrl;
               endcase
            end
            if (fall && state == ST_REPLY && bit_cnt != 3'h0) begin
               reply_sr <= {reply_sr[6:0], 1'b0};
            end
         end
      end
   end

   // reply line driven only during reply byte
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reply_out <= 1'b0;
         reply_oe <= 1'b0;
      end else begin
         reply_out <= reply_sr[7];
         reply_oe <= active && (state == ST_REPLY) && !reply_done;
      end
   end

   assign rxbuf_taken = rx_take;

   // full fifo drops the byte; host must pace writes
   scp_fifo #(
      .WIDTH(`SCP_BYTE_W),
      .DEPTH(`SCP_FIFO_DEPTH),
      .AW(`SCP_FIFO_AW)
   ) u_txq (
      .clk(clk),
      .rst_n(rst_n),
      .flush(1'b0),
      .in_valid(fifo_wr),
      .in_ready(fifo_in_ready),
      .in_data(fifo_wdata),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

   // low power only with both set
   assign low_power = res_s && ctrl[`SCP_CTRL_PSAVE_BIT];
   assign tone_oe = tx_active && !low_power;
   assign irq_out = 1'b0;
   assign irq_oe = irq_pending && ctrl[`SCP_CTRL_IRQEN_BIT];
endmodule // scp_port

// >>> scp_port_sva.sv
module scp_port_sva (
   input wire clk,
   input wire rst_n,
   input wire sel_n,
   input wire sclk,
   input wire reply_out,
   input wire reply_oe,
   input wire resume,
   input wire irq_pending,
   input wire irq_out,
   input wire irq_oe,
   input wire tx_active,
   input wire tone_oe,
   input wire [7:0] ctrl,
   input wire low_power
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sel_idle;
      sel_n [*4];
   endsequence
   tone_gate_a: assert property (tone_oe |-> tx_active && !low_power)
      else $error("tone enabled while not transmitting");
   tone_on_a: assert property (tx_active && !low_power |-> tone_oe)
      else $error("tone enable missing");
   reply_idle_a: assert property (sel_idle |-> !reply_oe)
      else $error("reply driven while deselected");
   reply_step_a: assert property (reply_oe && $past(reply_oe)
      && !$stable(reply_out) |-> !sclk) else $error("reply moved off clock");
   psave_on_a: assert property (resume [*4] ##0 ctrl[2] |-> low_power)
      else $error("low power not entered");
   psave_off_a: assert property (!resume [*4] |-> !low_power)
      else $error("low power held after wake");
   psave_bit_a: assert property (low_power |-> ctrl[2])
      else $error("low power without control bit");
   irq_pull_a: assert property (irq_oe |-> !irq_out && irq_pending)
      else $error("request line misdriven");
   irq_raise_a: assert property (irq_pending && ctrl[3] |-> irq_oe)
      else $error("request not raised");
   ctrl_quiet_a: assert property (sel_idle |=> $stable(ctrl))
      else $error("control changed outside frame");
endmodule // scp_port_sva

// >>> scp_host.sv
module scp_host (
   input wire logic clk,
   output logic sel_n,
   output logic sclk,
   output logic cmd_in,
   input wire logic reply_out,
   input wire logic reply_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      cmd_in = 1'b0;
   end
   task automatic shift(input logic b, output logic r);
      @(posedge clk) cmd_in <= b;
      repeat (15) @(posedge clk);
      sclk <= 1'b1;
      // undriven reply line shows the opposite level
      r = reply_oe ? reply_out : ~reply_out;
      repeat (16) @(posedge clk);
      sclk <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] op, input logic [15:0] d,
      input int n, output logic [7:0] rep);
      logic r;
      @(posedge clk) sel_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 7; i >= 0; i--) shift(op[i], r);
      for (int i = 0; i < n; i++) begin
         shift(d[15 - i], r);
         rep = {rep[6:0], r};
      end
      repeat (8) @(posedge clk);
      sel_n <= 1'b1;
      // released line must not look held
      cmd_in <= ~cmd_in;
      repeat (8) @(posedge clk);
   endtask
endmodule // scp_host

// >>> scp_port_tb.sv
module scp_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_n = 0, unit_addr = 0, resume = 1;
   logic irq_pending = 0, tx_active = 0, tx_ready = 0;
   logic [7:0] status_in = 0, rxbuf_in = 0, d, rep, q[$];
   logic [31:0] seed = 32'hFFA9BDCF;
   logic [15:0] w;
   wire sel_n, sclk, cmd_in, reply_out, reply_oe, rxbuf_taken;
   wire irq_out, irq_oe, tone_oe, tx_valid, low_power;
   wire [7:0] tx_data, ctrl;
   wire [15:0] sync_word;
   int errors = 0, checks_done = 0, rx_reads = 0;
   scp_port uut (.clk, .rst_n, .sel_n, .sclk, .cmd_in, .reply_out, .reply_oe,
      .unit_addr, .resume, .status_in, .rxbuf_in, .rxbuf_taken, .irq_pending,
      .irq_out, .irq_oe, .tx_active, .tone_oe, .tx_valid, .tx_ready,
      .tx_data, .ctrl, .sync_word, .low_power);
   scp_host host (.clk, .sel_n, .sclk, .cmd_in, .reply_out, .reply_oe);
   initial forever #2.5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string n, input logic [15:0] e, s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      seed <= lfsr(seed);
      tx_active <= seed[3];
      irq_pending <= seed[7];
      if (rxbuf_taken) rx_reads <= rx_reads + 1;
   end
   initial begin
      #400000;
      errors++;
      tally_and_finish;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      repeat (4) @(posedge clk);
      cmp("ctrl", 0, ctrl);
      host.xfer(8'h01, 0, 0, rep);
      for (int u = 0; u < 2; u++) begin
         unit_addr <= u[0];
         d = seed[15:8];
         host.xfer({4'h4, u[0], 3'h0}, {d, 8'h00}, 8, rep);
         cmp("ctrl", d, ctrl);
         host.xfer({4'h4, ~u[0], 3'h0}, {~d, 8'h00}, 8, rep);
         cmp("ctrl", d, ctrl);
      end
      host.xfer(8'h48, {~d, 8'h00}, 5, rep);
      cmp("ctrl", d, ctrl);
      w = seed[15:0] ^ 16'hA5C3;
      host.xfer(8'h4C, w, 16, rep);
      cmp("sync", w, sync_word);
      status_in <= seed[23:16];
      host.xfer(8'h49, 0, 8, rep);
      cmp("status", status_in, rep);
      rxbuf_in <= seed[30:23];
      host.xfer(8'h4A, 0, 8, rep);
      cmp("rxbuf", rxbuf_in, rep);
      cmp("taken", 1, rx_reads);
      host.xfer(8'h48, 16'h0C00, 8, rep);
      cmp("sleep", 1, low_power);
      resume <= 0;
      repeat (4) @(posedge clk);
      cmp("sleep", 0, low_power);
      resume <= 1;
      host.xfer(8'h01, 0, 0, rep);
      cmp("ctrl", 0, ctrl);
      for (int i = 0; i < 17; i++) begin
         d = seed[7:0];
         if (i < 16) q.push_back(d);
         host.xfer(8'h4B, {d, 8'h00}, 8, rep);
      end
      cmp("full", 1, tx_valid);
      for (int k = 0; k < 200 && q.size() > 0; k++) begin
         @(posedge clk);
         if (tx_valid && tx_ready) cmp("tx", q.pop_front(), tx_data);
         tx_ready <= seed[0];
      end
      @(posedge clk);
      tx_ready <= 0;
      cmp("left", 0, q.size());
      cmp("empty", 0, tx_valid);
      tally_and_finish;
   end
endmodule // scp_port_tb
bind scp_port scp_port_sva chk (.clk, .rst_n, .sel_n, .sclk, .reply_out,
   .reply_oe, .resume, .irq_pending, .irq_out, .irq_oe, .tx_active,
   .tone_oe, .ctrl, .low_power);
